// file: stage_fault.sv
`timescale 1ns/1ps
`default_nettype none
`include "stage_defs.svh"
module stage_fault #(
    parameter int WAKE_CYCLES = `WAKE_CYCLES,
    parameter int OC_CLEAR_CYCLES = `OC_CLEAR_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic gate_cmd_in,
    input wire logic over_current_in,
    input wire logic [7:0] die_temp_in,
    input wire logic supply_ok_in,
    input wire logic safety_on_in,
    input wire logic low_power_request_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic gate_drive_out,
    output logic status_out,
    output logic low_power_out
);
    // pins are asynchronous: two flops before any use
    logic [1:0] gate_s_r, oc_s_r, sup_s_r, safe_s_r, lpr_s_r;
    logic [7:0] temp_s1_r, temp_s2_r, temp_s3_r, temp_ok_r;
    // the temperature word crosses bit by bit: take it only once two samples agree, so a torn code is never used
    wire temp_settled = (temp_s2_r == temp_s3_r);
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            gate_s_r <= 2'h0;
            oc_s_r <= 2'h0;
            sup_s_r <= 2'h0;
            safe_s_r <= 2'h0;
            lpr_s_r <= 2'h0;
            temp_s1_r <= 8'h00;
            temp_s2_r <= 8'h00;
            temp_s3_r <= 8'h00;
            temp_ok_r <= 8'h00;
        end
        else
        begin
            gate_s_r <= {gate_s_r[0], gate_cmd_in};
            oc_s_r <= {oc_s_r[0], over_current_in};
            sup_s_r <= {sup_s_r[0], supply_ok_in};
            safe_s_r <= {safe_s_r[0], safety_on_in};
            lpr_s_r <= {lpr_s_r[0], low_power_request_in};
            temp_s1_r <= die_temp_in;
            temp_s2_r <= temp_s1_r;
            temp_s3_r <= temp_s2_r;
            temp_ok_r <= temp_settled ? temp_s2_r : temp_ok_r;
        end
    end
    wire gate = gate_s_r[1];
    wire oc = oc_s_r[1];
    wire supply_ok = sup_s_r[1];
    wire safety_on = safe_s_r[1];
    wire lp_req = lpr_s_r[1];

    // control register: bit 0 selects latched over-current handling
    logic [31:0] ctrl_r;
    wire latched_mode = ctrl_r[`CTRL_LATCH_BIT];

    // power state: low-power request low forces off, wake timer gates readiness
    stage_pkg::power_state_t pstate_r, pstate_nxt;
    logic wake_done;
    // the two sync flops, the off-to-wake and wake-to-run steps and the status flop come out of the pin-to-ready budget
    stage_timer #(.WIDTH(20)) wake_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(pstate_r == stage_pkg::ST_WAKE),
        .limit_in(20'(WAKE_CYCLES - 5)),
        .done_out(wake_done)
    );
    always_comb
    begin
        pstate_nxt = pstate_r;
        case (pstate_r)
            stage_pkg::ST_OFF: if (lp_req && supply_ok) pstate_nxt = stage_pkg::ST_WAKE;
            stage_pkg::ST_WAKE: if (wake_done) pstate_nxt = stage_pkg::ST_RUN;
            stage_pkg::ST_RUN: pstate_nxt = stage_pkg::ST_RUN;
            default: pstate_nxt = stage_pkg::ST_OFF;
        endcase
        if (!lp_req || !supply_ok)
            pstate_nxt = stage_pkg::ST_OFF;
    end

    // over-temperature with hysteresis
    logic ot_r;
    wire ot_nxt = ot_r ? (temp_ok_r >= (`OT_TRIP_DEGC - `OT_HYST_DEGC))
                       : (temp_ok_r > `OT_TRIP_DEGC);

    // over-current latch; set wins over clear
    logic oc_r;
    logic gate_low_long;
    stage_timer #(.WIDTH(20)) oc_clear_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(!gate),
        .limit_in(20'(OC_CLEAR_CYCLES)),
        .done_out(gate_low_long)
    );
    wire oc_clear = latched_mode ? gate_low_long : !gate;
    wire oc_nxt = oc || (oc_r && !oc_clear);

    wire ready = (pstate_r == stage_pkg::ST_RUN) && lp_req && safety_on && supply_ok;
    wire fault_free = !ot_r && !oc_r && !oc;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pstate_r <= stage_pkg::ST_OFF;
            ot_r <= 1'b0;
            oc_r <= 1'b0;
            status_out <= 1'b0;
            gate_drive_out <= 1'b0;
            low_power_out <= 1'b1;
        end
        else
        begin
            pstate_r <= pstate_nxt;
            ot_r <= ot_nxt;
            oc_r <= oc_nxt;
            status_out <= ready && fault_free;
            gate_drive_out <= gate && ready && fault_free;
            low_power_out <= (pstate_nxt == stage_pkg::ST_OFF);
        end
    end

    // apb slave, zero wait states
    wire acc = psel && penable;
    wire hit_ctrl = (paddr == `ADDR_CTRL);
    wire hit_stat = (paddr == `ADDR_STATUS);
    wire hit_temp = (paddr == `ADDR_TEMP);
    wire mapped = hit_ctrl || hit_stat || hit_temp;
    wire [31:0] stat_word = {25'h0, pstate_r, oc_r, ot_r, supply_ok, safety_on, status_out};
    wire [31:0] rd_word = hit_ctrl ? ctrl_r : hit_stat ? stat_word : hit_temp ? {24'h0, temp_ok_r} : 32'h0;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ctrl_r <= `CTRL_RESET_VAL;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            if (acc && pwrite && hit_ctrl)
                ctrl_r <= {31'h0, pwdata[0]};
            if (psel && !penable && !pwrite)
                prdata <= rd_word;
        end
    end

    property p_status_needs_safety;
        @(posedge clk_in) disable iff (rst_in) !safety_on |=> !status_out;
    endproperty
    a_status_needs_safety: assert property (p_status_needs_safety) else $error("status high before safety on");
    property p_uvlo_blocks;
        @(posedge clk_in) disable iff (rst_in) !supply_ok |=> !gate_drive_out && !status_out;
    endproperty
    a_uvlo_blocks: assert property (p_uvlo_blocks) else $error("switching during undervoltage");
    property p_ot_holds;
        @(posedge clk_in) disable iff (rst_in) ot_r |=> !gate_drive_out;
    endproperty
    a_ot_holds: assert property (p_ot_holds) else $error("switch on during over-temperature");
    property p_ot_trip;
        @(posedge clk_in) disable iff (rst_in) (temp_ok_r > `OT_TRIP_DEGC) |=> ot_r;
    endproperty
    a_ot_trip: assert property (p_ot_trip) else $error("missed temperature trip");
    property p_oc_latch;
        @(posedge clk_in) disable iff (rst_in) latched_mode && oc_r && gate |=> oc_r;
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("latched fault cleared with gate high");
    property p_cbc_clear;
        @(posedge clk_in) disable iff (rst_in) !latched_mode && !gate && !oc |=> !oc_r;
    endproperty
    a_cbc_clear: assert property (p_cbc_clear) else $error("cycle fault not released");
    property p_fault_status;
        @(posedge clk_in) disable iff (rst_in) oc_r |=> !status_out;
    endproperty
    a_fault_status: assert property (p_fault_status) else $error("status high during fault");
    property p_lowpower;
        @(posedge clk_in) disable iff (rst_in) !lp_req |=> low_power_out && !status_out;
    endproperty
    a_lowpower: assert property (p_lowpower) else $error("not in low power");

    // cycles spent waking with the request up and the supplies good
    logic [19:0] wake_age_r;
    wire waking = lp_req && supply_ok && (pstate_r != stage_pkg::ST_RUN);
    always_ff @(posedge clk_in)
    begin
        if (rst_in || !waking)
            wake_age_r <= 20'h00000;
        else
            wake_age_r <= wake_age_r + 20'h00001;
    end
    property p_wake_bound;
        @(posedge clk_in) disable iff (rst_in) wake_age_r <= 20'(WAKE_CYCLES - 3);
    endproperty
    a_wake_bound: assert property (p_wake_bound) else $error("wake takes too long");
    property p_not_run_quiet;
        @(posedge clk_in) disable iff (rst_in) (pstate_r != stage_pkg::ST_RUN) |=> !status_out;
    endproperty
    a_not_run_quiet: assert property (p_not_run_quiet) else $error("status high before wake done");
    property p_oc_gate_off;
        @(posedge clk_in) disable iff (rst_in) oc |=> !gate_drive_out;
    endproperty
    a_oc_gate_off: assert property (p_oc_gate_off) else $error("switch on during over-current");
    property p_latch_clear;
        @(posedge clk_in) disable iff (rst_in) latched_mode && oc_r && gate_low_long && !oc |=> !oc_r;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latched fault not cleared");
    property p_ot_release;
        @(posedge clk_in) disable iff (rst_in) ot_r && (temp_ok_r < (`OT_TRIP_DEGC - `OT_HYST_DEGC)) |=> !ot_r;
    endproperty
    a_ot_release: assert property (p_ot_release) else $error("temperature trip not released");
endmodule
`default_nettype wire

// file: stage_defs.svh
// Notes on behaviour
// - an over-temperature fault is raised when the die temperature rises above the trip level, 165 degrees C.
// - after a temperature trip the switch stays off until the temperature falls more than 15 degrees below the trip level.
// - the status output is push-pull; high means ready and fault-free, low means not ready or faulted.
// - during startup the status output stays low until the series safety transistor is on.
// - after an over-current or over-temperature fault the status stays low until the latch is reset or the fault clears.
// - a supply below its lockout level stops all switching and holds status low until supplies recover.
// - a low level on the low-power request pin puts the device into its low-power state.
// - after the low-power request pin rises the device is ready to switch within 1 ms.
// - in latched mode an over-current keeps the switch off until the gate command stays low over 350 us.
// - in cycle-by-cycle mode an over-current turns the switch off and clears once the gate command goes low.
`ifndef STAGE_DEFS_SVH
`define STAGE_DEFS_SVH

`define CLK_PERIOD_NS 10
`define OT_TRIP_DEGC 8'hA5
`define OT_HYST_DEGC 8'h0F
`define WAKE_TIME_US 1000
`define WAKE_CYCLES ((`WAKE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define OC_CLEAR_TIME_US 350
`define OC_CLEAR_CYCLES (((`OC_CLEAR_TIME_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_TEMP 12'h008
`define CTRL_LATCH_BIT 0
`define CTRL_RESET_VAL 32'h0000_0001

`endif

// file: stage_pkg.sv
package stage_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WAKE = 2'b01,
        ST_RUN = 2'b10
    } power_state_t;
endpackage

// file: stage_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts while run_in is high; done_out once the count reaches limit
module stage_timer #(
    parameter int WIDTH = 20
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [WIDTH-1:0] limit_in,
    output logic done_out
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    wire reached = (count_r >= limit_in);

    assign count_nxt = !run_in ? '0 : (reached ? count_r : count_r + 1'b1);
    assign done_out = run_in && reached;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end
endmodule
`default_nettype wire

// file: stage_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: pulses only while allowed and while the stage reports ready
module stage_ctrl_model #(
    parameter int PERIOD = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic status_in,
    input wire logic pulse_en_in,
    output logic gate_cmd_out,
    output logic drive_strength_set_out
);
    // soft start: on-time grows by one cycle per period, from one cycle up to the whole period
    logic [7:0] phase_r;
    logic [7:0] duty_r;
    always_ff @(posedge clk_in)
    begin
        drive_strength_set_out <= !rst_in && status_in;
        if (rst_in || !status_in)
        begin
            phase_r <= 8'h00;
            duty_r <= 8'h01;
            gate_cmd_out <= 1'b0;
        end
        else
        begin
            phase_r <= (phase_r == 8'(PERIOD - 1)) ? 8'h00 : phase_r + 8'h01;
            if (phase_r == 8'(PERIOD - 1) && duty_r != 8'(PERIOD))
                duty_r <= duty_r + 8'h01;
            gate_cmd_out <= pulse_en_in && (phase_r < duty_r);
        end
    end
endmodule
`default_nettype wire

// file: test_stage_fault.sv
`timescale 1ns/1ps
`default_nettype none
module test_stage_fault;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic oc = 1'b0, sup = 1'b1, safe = 1'b0, lpr = 1'b1, pen = 1'b1;
    logic [7:0] temp = 8'h19;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, gate_cmd, gate_drive, status, low_pwr, drive_set;
    int failures = 0, cmp_count = 0, cycles = 0;
    stage_ctrl_model stage_ctrl_model_i (.clk_in(clk_in), .rst_in(rst_in), .status_in(status),
        .pulse_en_in(pen), .gate_cmd_out(gate_cmd), .drive_strength_set_out(drive_set));
    stage_fault #(.WAKE_CYCLES(20), .OC_CLEAR_CYCLES(10)) stage_fault_i (.clk_in(clk_in), .rst_in(rst_in),
        .gate_cmd_in(gate_cmd), .over_current_in(oc), .die_temp_in(temp), .supply_ok_in(sup),
        .safety_on_in(safe), .low_power_request_in(lpr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gate_drive_out(gate_drive), .status_out(status), .low_power_out(low_pwr));
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end
    task wrap_up;
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    initial
    begin
        cyc(8);
        rst_in <= 1'b0;
        cyc(40);
        chk(status, 1'b0);
        safe <= 1'b1;
        cyc(9);
        chk({status, gate_drive}, 2'b10);
        cyc(15);
        chk({status, gate_drive, drive_set}, 3'b111);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0047);
        temp <= 8'hA5;
        cyc(8);
        chk(status, 1'b1);
        temp <= 8'hA6;
        cyc(8);
        chk({status, gate_drive}, 2'b00);
        temp <= 8'h96;
        cyc(8);
        chk({status, gate_drive}, 2'b00);
        temp <= 8'h95;
        cyc(8);
        chk(status, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0000_0095);
        for (int m = 1; m >= 0; m--)
        begin
            apb(1'b1, 12'h000, 32'(m));
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, 32'(m));
            oc <= 1'b1;
            cyc(3);
            oc <= 1'b0;
            cyc(11);
            chk(status, 1'(m == 0));
            cyc(30);
            chk(status, 1'b1);
        end
        sup <= 1'b0;
        cyc(8);
        chk({status, gate_drive}, 2'b00);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0002);
        sup <= 1'b1;
        cyc(8);
        chk(status, 1'b0);
        cyc(30);
        chk(status, 1'b1);
        lpr <= 1'b0;
        cyc(8);
        chk({low_pwr, status}, 2'b10);
        lpr <= 1'b1;
        cyc(12);
        chk(status, 1'b0);
        cyc(30);
        chk({low_pwr, status}, 2'b01);
        apb(1'b0, 12'h00C, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk({er, rd}, {1'b0, 32'h0000_0047});
        wrap_up();
    end
endmodule
`default_nettype wire
